// File: pkg/seq_pkg.sv
// Purpose: shared types and constants for the operand bus sequencer
// Assumes: 8-bit data, 16-bit address, one processor clock
// Notes:   mode codes are the block's own encoding of the addressing mode
package seq_pkg;

  // ************************************************************
  // widths and reset values
  // ************************************************************
  localparam int          ADDR_W     = 16;
  localparam int          DATA_W     = 8;
  localparam logic [15:0] PC_RESET   = 16'h0000; // start address after reset
  localparam logic [7:0]  PAGE_ZERO  = 8'h00;    // high byte of page zero
  localparam logic [15:0] PC_ONE     = 16'h0001; // program counter step

  // ************************************************************
  // addressing modes
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_IMM,
    MODE_ZP,
    MODE_ABS,
    MODE_IND_X,
    MODE_ABS_IDX,
    MODE_ZP_IDX,
    MODE_IND_Y
  } addr_mode_t;

  // decoded instruction handed in by the decoder
  typedef struct packed {
    addr_mode_t  mode;     // addressing mode
    logic        store;    // 1 = store group, 0 = operand read group
    logic        use_y;    // index register select, 1 = Y
  } instr_info_t;

  // one bus cycle as seen at the pins
  typedef struct packed {
    logic [15:0] addr;     // address bus
    logic        rd_wr;    // 1 = read, 0 = write
    logic [7:0]  wdata;    // data driven on a write
    logic        wr_en;    // data bus output enable
  } bus_cycle_t;

endpackage : seq_pkg

// File: verification/bus_mem.sv
// Purpose: memory model on the far side of the sequencer's system bus
// Assumes: every read cycle is answered in the same cycle, no wait states
// Notes:   the test bench loads bytes straight into mem

module bus_mem
(
  input  wire logic                core_clk, // processor clock
  input  wire seq_pkg::bus_cycle_t bus,      // cycle driven by the sequencer
  output      logic [7:0]          rdata     // data bus back to the core
);
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // storage
  // ************************************************************
  logic [7:0] mem [0:65535]; // whole address space

  // filled so that no read of an unloaded place returns unknowns
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i * 7);
  end

  // memory is not driving in a write cycle, so show a changed value
  assign rdata = bus.rd_wr ? mem[bus.addr] : ~mem[bus.addr];

  // write cycles land at the end of the cycle
  always @(posedge core_clk)
  begin
    if (!bus.rd_wr && bus.wr_en)
      mem[bus.addr] <= bus.wdata;
  end
endmodule : bus_mem

// File: verification/memory_operand_bus_sequencer_sva.sv
// Purpose: port checker for the operand bus sequencer
// Assumes: one clock, rst asynchronous active high
// Notes:   bound to every instance of the sequencer

module seq_checker
(
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire logic [7:0]           rdata,
  input wire seq_pkg::instr_info_t info,
  input wire logic [7:0]           index_x,
  input wire logic [7:0]           index_y,
  input wire logic [7:0]           store_val,
  input wire seq_pkg::bus_cycle_t  bus,
  input wire logic                 opcode_fetch,
  input wire logic [7:0]           opcode_r,
  input wire logic                 operand_valid,
  input wire logic [7:0]           operand_r,
  input wire logic [2:0]           cycle_step_number
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ************************************************************
  // bus cycle checks
  // ************************************************************
  fetch_read_a: assert property (
    opcode_fetch |-> bus.rd_wr && !bus.wr_en)
    else $error("opcode fetch is not a read");
  // the cycle after an opcode fetch reads the next program byte
  fetch_step_a: assert property (
    opcode_fetch |=> !opcode_fetch && bus.rd_wr &&
    bus.addr == $past(bus.addr) + 16'h0001)
    else $error("cycle after opcode fetch not at pc plus one");
  step_adv_a: assert property (!opcode_fetch |->
    cycle_step_number == $past(cycle_step_number) + 3'h1)
    else $error("step counter skipped");
  step_max_a: assert property (cycle_step_number <= 3'h5)
    else $error("step beyond six cycles");
  // write data is the register seen one edge earlier
  write_data_a: assert property (!bus.rd_wr |->
    bus.wr_en && bus.wdata == $past(store_val))
    else $error("write cycle data wrong");
  store_end_a: assert property (
    !bus.rd_wr |=> opcode_fetch && !operand_valid)
    else $error("store did not end cleanly");
  valid_fetch_a: assert property (
    operand_valid |-> opcode_fetch)
    else $error("operand not during opcode fetch");
  operand_data_a: assert property (
    operand_valid |-> operand_r == $past(rdata))
    else $error("operand is not the last read byte");
  // step 2 of every page-zero based mode stays in page zero
  page_zero_a: assert property (cycle_step_number == 3'h2 &&
    $past(info.mode, 2) inside {seq_pkg::MODE_ZP, seq_pkg::MODE_ZP_IDX,
    seq_pkg::MODE_IND_X, seq_pkg::MODE_IND_Y}
    |-> bus.addr[15:8] == seq_pkg::PAGE_ZERO)
    else $error("page zero cycle left page zero");

  cover property (operand_valid);
  cover property (!bus.rd_wr);
  cover property (cycle_step_number == 3'h5);
endmodule : seq_checker

bind memory_operand_bus_sequencer seq_checker seq_checker_i
(
  .core_clk(core_clk), .rst(rst), .rdata(rdata), .info(info),
  .index_x(index_x), .index_y(index_y), .store_val(store_val), .bus(bus),
  .opcode_fetch(opcode_fetch), .opcode_r(opcode_r),
  .operand_valid(operand_valid), .operand_r(operand_r),
  .cycle_step_number(cycle_step_number)
);

// File: verification/tb_memory_operand_bus_sequencer.sv
// Purpose: self-checking bench for the operand bus sequencer
// Assumes: opcode bits [2:0] mode, [3] store, [4] index y (bench decode)
// Notes:   program bytes are written just ahead of the program counter

module tb_memory_operand_bus_sequencer;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 core_clk, rst, opcode_fetch, operand_valid;
  logic [7:0]           rdata, index_x, index_y, store_val, opcode_r;
  logic [7:0]           operand_r;
  logic [2:0]           cycle_step_number;
  seq_pkg::instr_info_t info;
  seq_pkg::bus_cycle_t  bus;
  logic [15:0]          pc;                 // expected program counter
  int                   mismatches, n_checks, cycles;

  // bench decoder, combinational from the data bus
  assign info = '{mode: seq_pkg::addr_mode_t'(rdata[2:0]),
                  store: rdata[3], use_y: rdata[4]};

  memory_operand_bus_sequencer memory_operand_bus_sequencer_i
  (
    .core_clk(core_clk), .rst(rst), .rdata(rdata), .info(info),
    .index_x(index_x), .index_y(index_y), .store_val(store_val),
    .bus(bus), .opcode_fetch(opcode_fetch), .opcode_r(opcode_r),
    .operand_valid(operand_valid), .operand_r(operand_r),
    .cycle_step_number(cycle_step_number)
  );
  bus_mem bus_mem_i (.core_clk(core_clk), .bus(bus), .rdata(rdata));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard, the whole run needs about 96 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      mismatches++;
      summarize();
    end
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      $display("wrong value at %0t: got %h exp %h", $time, s, e);
      mismatches++;
    end
  endtask : chk

  task automatic ld(input logic [15:0] a, input logic [7:0] d);
    bus_mem_i.mem[a] = d;
  endtask : ld

  // check one bus cycle, then move just past the next edge
  task automatic cyc(input logic [15:0] a, input logic rw);
    chk(bus.addr, a);
    chk(16'(bus.rd_wr), 16'(rw));
    @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic op(input seq_pkg::addr_mode_t m, input logic st, y);
    ld(pc, {3'h0, y, st, m});
    store_val = pc[7:0] ^ 8'h6B;
    cyc(pc, 1'b1);
    chk(16'(opcode_r), 16'({3'h0, y, st, m}));
    chk(16'(cycle_step_number), 16'h0001);
  endtask : op

  // last cycle, then judge the result at the next opcode fetch
  task automatic fin(input logic [15:0] a, input logic st, input logic [7:0] d);
    ld(a, d);
    if (st)
      chk(16'(bus.wdata), 16'(store_val));
    cyc(a, !st);
    chk(16'(operand_valid), 16'(!st));
    if (!st)
      chk(16'(operand_r), 16'(d));
    else
      chk(16'(bus_mem_i.mem[a]), 16'(store_val));
    chk(16'(opcode_fetch), 16'h1);
  endtask : fin

  // indexed tail: extra cycle on a page cross, always for stores
  task automatic idx_end(input logic [7:0] hi, lo, input logic st, cr,
                         input logic [7:0] d);
    if (cr)
    begin
      chk(16'(bus.addr[7:0]), 16'(lo));
      cyc({hi, lo}, 1'b1);
    end
    else if (st)
      cyc({hi, lo}, 1'b1);
    fin({hi + 8'(cr), lo}, st, d);
  endtask : idx_end

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_imm();
    op(seq_pkg::MODE_IMM, 1'b0, 1'b0);
    fin(pc + 16'h1, 1'b0, 8'h3C);
    pc = pc + 16'h2;
  endtask : t_imm

  // unused mode code: one step at pc+1, no operand, next opcode
  task automatic t_bad();
    ld(pc, 8'h07);
    cyc(pc, 1'b1);
    chk(16'(opcode_r), 16'h0007);
    cyc(pc + 16'h1, 1'b1);
    chk(16'(operand_valid), 16'h0000);
    chk(16'(opcode_fetch), 16'h0001);
    chk(bus.addr, pc + 16'h2);
    pc = pc + 16'h2;
  endtask : t_bad

  task automatic t_zp(input logic st);
    op(seq_pkg::MODE_ZP, st, 1'b0);
    ld(pc + 16'h1, 8'h80);
    cyc(pc + 16'h1, 1'b1);
    fin(16'h0080, st, 8'h11);
    pc = pc + 16'h2;
  endtask : t_zp

  task automatic t_abs(input logic st);
    op(seq_pkg::MODE_ABS, st, 1'b0);
    ld(pc + 16'h1, 8'h34);
    ld(pc + 16'h2, 8'h12);
    cyc(pc + 16'h1, 1'b1);
    cyc(pc + 16'h2, 1'b1);
    fin(16'h1234, st, 8'h22);
    pc = pc + 16'h3;
  endtask : t_abs

  // base plus x wraps inside page zero
  task automatic t_indx(input logic st);
    op(seq_pkg::MODE_IND_X, st, 1'b0);
    index_x = 8'hA0;
    ld(pc + 16'h1, 8'hF0);
    ld(16'h0090, 8'h78);
    ld(16'h0091, 8'h56);
    cyc(pc + 16'h1, 1'b1);
    cyc(16'h00F0, 1'b1);
    cyc(16'h0090, 1'b1);
    cyc(16'h0091, 1'b1);
    fin(16'h5678, st, 8'h33);
    pc = pc + 16'h2;
  endtask : t_indx

  task automatic t_zpidx(input logic st);
    op(seq_pkg::MODE_ZP_IDX, st, 1'b0);
    index_x = 8'hC0;
    ld(pc + 16'h1, 8'hE0);
    cyc(pc + 16'h1, 1'b1);
    cyc(16'h00E0, 1'b1);
    fin(16'h00A0, st, 8'h55);
    pc = pc + 16'h2;
  endtask : t_zpidx

  task automatic t_absidx(input logic st, cr);
    op(seq_pkg::MODE_ABS_IDX, st, 1'b1);
    index_y = cr ? 8'hF0 : 8'h05;
    ld(pc + 16'h1, 8'h20);
    ld(pc + 16'h2, 8'h41);
    cyc(pc + 16'h1, 1'b1);
    cyc(pc + 16'h2, 1'b1);
    idx_end(8'h41, 8'h20 + index_y, st, cr, 8'h44);
    pc = pc + 16'h3;
  endtask : t_absidx

  task automatic t_indy(input logic st, cr);
    op(seq_pkg::MODE_IND_Y, st, 1'b1);
    index_y = cr ? 8'hF0 : 8'h05;
    ld(pc + 16'h1, 8'hB0);
    ld(16'h00B0, 8'h20);
    ld(16'h00B1, 8'h63);
    cyc(pc + 16'h1, 1'b1);
    cyc(16'h00B0, 1'b1);
    cyc(16'h00B1, 1'b1);
    idx_end(8'h63, 8'h20 + index_y, st, cr, 8'h66);
    pc = pc + 16'h2;
  endtask : t_indy

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    rst = 1'b1;
    index_x = 8'h00;
    index_y = 8'h00;
    store_val = 8'h00;
    pc = seq_pkg::PC_RESET;
    repeat (16) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_imm();
    t_bad();
    for (int s = 0; s < 2; s++)
    begin
      t_zp(s[0]);
      t_abs(s[0]);
      t_indx(s[0]);
      t_zpidx(s[0]);
      for (int c = 0; c < 2; c++)
      begin
        t_absidx(s[0], c[0]);
        t_indy(s[0], c[0]);
      end
    end
    summarize();
  end
endmodule : tb_memory_operand_bus_sequencer

// File: verilog/memory_operand_bus_sequencer.sv
// Purpose: bus cycle sequencer for operand read and store instructions
// Assumes: decoder supplies mode info combinationally from the opcode
// Notes:   execution of read results is left to the datapath
//
// Functional notes
// - each instruction starts with opcode fetch, read
// - zero to four address cycles, then operand read
// - read result executes during next opcode fetch
// - immediate: two cycles, operand at pc+1
// - zero page read: three cycles, high zero
// - absolute read: four cycles, next at pc+3
// - pre-indexed indirect read: six cycles, page zero
// - absolute indexed: base low plus index, carry
// - page cross adds cycle with incremented high
// - zero page indexed: four cycles, wraps in page
// - post-indexed indirect read: five or six cycles
// - post-indexed page cross adds sixth cycle
// - stores replace final read with write cycle
// - stores never overlap, never skip extra cycle
// - zero page store: three cycles
// - absolute store: four cycles
// - pre-indexed indirect store: six cycles
module memory_operand_bus_sequencer
(
  input  wire logic                core_clk,  // processor clock
  input  wire logic                rst,       // async reset, active high
  input  wire logic [7:0]          rdata,     // data bus in
  input  wire seq_pkg::instr_info_t info,     // decoded opcode info
  input  wire logic [7:0]          index_x,   // x register
  input  wire logic [7:0]          index_y,   // y register
  input  wire logic [7:0]          store_val, // register to store
  output      seq_pkg::bus_cycle_t bus,       // address, r/w, write data
  output      logic                opcode_fetch, // this cycle fetches opcode
  output      logic [7:0]          opcode_r,  // latched opcode
  output      logic                operand_valid, // operand ready pulse
  output      logic [7:0]          operand_r, // operand for execution
  output      logic [2:0]          cycle_step_number // current step
);

  // ************************************************************
  // state
  // ************************************************************
  logic [15:0]          pc_r, pc_nxt;           // program counter
  logic [2:0]           step_r, step_nxt;       // cycle step counter
  seq_pkg::instr_info_t inst_r, inst_nxt;       // info held for the op
  logic [7:0]           base_addr_low_r, base_addr_low_nxt;
  logic [7:0]           base_addr_high_r, base_addr_high_nxt;
  logic [7:0]           indirect_ptr_low_r, indirect_ptr_low_nxt;
  logic                 carry_r, carry_nxt;     // low byte add carry
  logic [7:0]           opcode_nxt;
  logic [7:0]           operand_nxt;
  logic                 operand_valid_nxt;
  logic                 operand_valid_r;
  seq_pkg::bus_cycle_t  bus_r, bus_nxt;         // registered pin values

  // ************************************************************
  // helpers
  // ************************************************************
  // low byte add with carry out, shared by all four indexed modes
  function automatic logic [8:0] add_low(input logic [7:0] a,
                                         input logic [7:0] b);
    add_low = {1'b0, a} + {1'b0, b};
  endfunction : add_low

  // read cycle at a given address
  function automatic seq_pkg::bus_cycle_t rd_at(input logic [15:0] a);
    rd_at = '{addr: a, rd_wr: 1'b1, wdata: 8'h00, wr_en: 1'b0};
  endfunction : rd_at

  logic [7:0] idx;       // selected index register
  logic [8:0] sum_low;   // base low plus index
  logic       last;      // this step ends the instruction
  logic       final_acc; // the step that takes or writes the operand

  assign idx = inst_r.use_y ? index_y : index_x;

  // ************************************************************
  // sequencer next state
  // ************************************************************
  // bus_r holds the cycle now on the pins; the comb block decides
  // what the next cycle drives, so addresses come from flip-flops
  always_comb
  begin
    pc_nxt               = pc_r;
    step_nxt             = step_r + 3'h1;
    inst_nxt             = inst_r;
    base_addr_low_nxt    = base_addr_low_r;
    base_addr_high_nxt   = base_addr_high_r;
    indirect_ptr_low_nxt = indirect_ptr_low_r;
    carry_nxt            = carry_r;
    opcode_nxt           = opcode_r;
    operand_nxt          = operand_r;
    operand_valid_nxt    = 1'b0;
    last                 = 1'b0;
    final_acc            = 1'b0;
    sum_low              = add_low(base_addr_low_r, idx);
    bus_nxt              = rd_at(pc_r);

    if (step_r == 3'h0)
    begin
      // opcode on data bus now; latch it and its decoded mode
      opcode_nxt = rdata;
      inst_nxt   = info;
      pc_nxt     = pc_r + seq_pkg::PC_ONE;
      bus_nxt    = rd_at(pc_r + seq_pkg::PC_ONE);
    end
    else
    begin
      unique case (inst_r.mode)
        seq_pkg::MODE_IMM:
        begin
          // step 1 read operand at pc+1
          final_acc = 1'b1;
          last      = 1'b1;
        end
        seq_pkg::MODE_ZP:
        begin
          if (step_r == 3'h1)
          begin
            // eff_addr_low fetched, next cycle hits page zero
            base_addr_low_nxt = rdata;
            bus_nxt = rd_at({seq_pkg::PAGE_ZERO, rdata});
            bus_nxt.rd_wr = ~inst_r.store;
            bus_nxt.wr_en = inst_r.store;
            bus_nxt.wdata = store_val;
          end
          else
          begin
            final_acc = 1'b1;
            last      = 1'b1;
          end
        end
        seq_pkg::MODE_ABS, seq_pkg::MODE_ABS_IDX:
        begin
          if (step_r == 3'h1)
          begin
            base_addr_low_nxt = rdata;
            bus_nxt = rd_at(pc_r + seq_pkg::PC_ONE);
          end
          else if (step_r == 3'h2)
          begin
            base_addr_high_nxt = rdata;
            if (inst_r.mode == seq_pkg::MODE_ABS)
            begin
              bus_nxt = rd_at({rdata, base_addr_low_r});
              bus_nxt.rd_wr = ~inst_r.store;
              bus_nxt.wr_en = inst_r.store;
              bus_nxt.wdata = store_val;
            end
            else
            begin
              // high byte here uses no carry yet; fixed in step 4
              carry_nxt = sum_low[8];
              bus_nxt   = rd_at({rdata, sum_low[7:0]});
              // a store always takes the extra cycle as a dummy read
              bus_nxt.rd_wr = 1'b1;
            end
          end
          else if (step_r == 3'h3 && inst_r.mode == seq_pkg::MODE_ABS_IDX
                   && (carry_r || inst_r.store))
          begin
            // page crossed or store: discard, redo with high + carry
            bus_nxt = rd_at({base_addr_high_r + {7'h00, carry_r},
                             sum_low[7:0]});
            bus_nxt.rd_wr = ~inst_r.store;
            bus_nxt.wr_en = inst_r.store;
            bus_nxt.wdata = store_val;
          end
          else
          begin
            final_acc = 1'b1;
            last      = 1'b1;
          end
        end
        seq_pkg::MODE_ZP_IDX:
        begin
          if (step_r == 3'h1)
          begin
            base_addr_low_nxt = rdata;
            bus_nxt = rd_at({seq_pkg::PAGE_ZERO, rdata});
          end
          else if (step_r == 3'h2)
          begin
            // carry dropped: index wraps inside page zero
            bus_nxt = rd_at({seq_pkg::PAGE_ZERO, sum_low[7:0]});
            bus_nxt.rd_wr = ~inst_r.store;
            bus_nxt.wr_en = inst_r.store;
            bus_nxt.wdata = store_val;
          end
          else
          begin
            final_acc = 1'b1;
            last      = 1'b1;
          end
        end
        seq_pkg::MODE_IND_X:
        begin
          if (step_r == 3'h1)
          begin
            base_addr_low_nxt = rdata;
            bus_nxt = rd_at({seq_pkg::PAGE_ZERO, rdata});
          end
          else if (step_r == 3'h2)
            bus_nxt = rd_at({seq_pkg::PAGE_ZERO, sum_low[7:0]});
          else if (step_r == 3'h3)
          begin
            indirect_ptr_low_nxt = rdata;               // eff_addr_low
            bus_nxt = rd_at({seq_pkg::PAGE_ZERO,
                             sum_low[7:0] + 8'h01});
          end
          else if (step_r == 3'h4)
          begin
            bus_nxt = rd_at({rdata, indirect_ptr_low_r});
            bus_nxt.rd_wr = ~inst_r.store;
            bus_nxt.wr_en = inst_r.store;
            bus_nxt.wdata = store_val;
          end
          else
          begin
            final_acc = 1'b1;
            last      = 1'b1;
          end
        end
        seq_pkg::MODE_IND_Y:
        begin
          if (step_r == 3'h1)
          begin
            indirect_ptr_low_nxt = rdata;
            bus_nxt = rd_at({seq_pkg::PAGE_ZERO, rdata});
          end
          else if (step_r == 3'h2)
          begin
            base_addr_low_nxt = rdata;
            bus_nxt = rd_at({seq_pkg::PAGE_ZERO,
                             indirect_ptr_low_r + 8'h01});
          end
          else if (step_r == 3'h3)
          begin
            base_addr_high_nxt = rdata;
            carry_nxt = sum_low[8];
            bus_nxt   = rd_at({rdata, sum_low[7:0]});
          end
          else if (step_r == 3'h4 && (carry_r || inst_r.store))
          begin
            bus_nxt = rd_at({base_addr_high_r + {7'h00, carry_r},
                             sum_low[7:0]});
            bus_nxt.rd_wr = ~inst_r.store;
            bus_nxt.wr_en = inst_r.store;
            bus_nxt.wdata = store_val;
          end
          else
          begin
            final_acc = 1'b1;
            last      = 1'b1;
          end
        end
        default:
        begin
          // unused mode code: end the instruction at once
          last = 1'b1;
        end
      endcase
    end

    if (last)
    begin
      // next opcode address follows the last instruction byte
      step_nxt = 3'h0;
      bus_nxt  = rd_at(pc_nxt);
      if (inst_r.mode == seq_pkg::MODE_IMM)
      begin
        pc_nxt  = pc_r + seq_pkg::PC_ONE;
        bus_nxt = rd_at(pc_nxt);
      end
      // operand bytes consumed beyond the opcode bump pc
      unique case (inst_r.mode)
        seq_pkg::MODE_ABS, seq_pkg::MODE_ABS_IDX:
          pc_nxt = pc_r + 16'h0002;
        seq_pkg::MODE_IMM:
          pc_nxt = pc_r + seq_pkg::PC_ONE;
        default:
          pc_nxt = pc_r + seq_pkg::PC_ONE;
      endcase
      bus_nxt = rd_at(pc_nxt);
      if (final_acc && !inst_r.store)
      begin
        // executes while next opcode is fetched, no extra cycle
        operand_nxt       = rdata;
        operand_valid_nxt = 1'b1;
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pc_r               <= seq_pkg::PC_RESET;
      step_r             <= 3'h0;
      inst_r             <= '0;
      base_addr_low_r    <= 8'h00;
      base_addr_high_r   <= 8'h00;
      indirect_ptr_low_r <= 8'h00;
      carry_r            <= 1'b0;
      opcode_r           <= 8'h00;
      operand_r          <= 8'h00;
      operand_valid_r    <= 1'b0;
      bus_r              <= '{addr: seq_pkg::PC_RESET, rd_wr: 1'b1,
                              wdata: 8'h00, wr_en: 1'b0};
    end
    else
    begin
      pc_r               <= pc_nxt;
      step_r             <= step_nxt;
      inst_r             <= inst_nxt;
      base_addr_low_r    <= base_addr_low_nxt;
      base_addr_high_r   <= base_addr_high_nxt;
      indirect_ptr_low_r <= indirect_ptr_low_nxt;
      carry_r            <= carry_nxt;
      opcode_r           <= opcode_nxt;
      operand_r          <= operand_nxt;
      operand_valid_r    <= operand_valid_nxt;
      bus_r              <= bus_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign bus               = bus_r;
  assign cycle_step_number = step_r;
  assign opcode_fetch      = (step_r == 3'h0);
  assign operand_valid     = operand_valid_r;

endmodule : memory_operand_bus_sequencer

// File: verilog/unused_placeholder_removed.sv
// Purpose: none
// Assumes: none
// Notes:   intentionally empty
